// ---- design/fsec_defines.svh ----
// register offsets, field positions, reset values and counts of the flash security block
`ifndef FSEC_DEFINES_SVH
`define FSEC_DEFINES_SVH

// apb byte offsets, one aligned word each
`define FSEC_OFF_DIVIDER 12'h000
`define FSEC_OFF_OPTIONS 12'h004
`define FSEC_OFF_CONFIG 12'h008
`define FSEC_OFF_STATUS 12'h00C

// options shadow fields
`define FSEC_OPT_BACKDOOR_ENABLE_BIT 7
`define FSEC_OPT_REDIR_BIT 6
`define FSEC_OPT_IMPL_MASK 8'hC3
`define FSEC_OPT_RESET 8'h00
`define FSEC_SEC_UNSECURED 2'h2

// configuration fields
`define FSEC_CFG_KEYWEN_BIT 5
`define FSEC_CFG_IMPL_MASK 8'hE0
`define FSEC_CFG_RESET 3'h0

// divider fields
`define FSEC_DIV_LOADED_BIT 7
`define FSEC_DIV_PRESCALE_BIT 6
`define FSEC_DIV_RESET 7'h00

// status fields
`define FSEC_STAT_SECURE_BIT 0
`define FSEC_STAT_LOADED_BIT 1

// key window and counts
`define FSEC_KEY_BASE 16'hFFB0
`define FSEC_KEY_BYTES 4'h8
`define FSEC_PRESCALE_LAST 3'h7
`define FSEC_INVALID_READ 8'h00

`endif

// ---- design/fsec_pkg.sv ----
// types and shared decode of the flash security block
`include "fsec_defines.svh"

package fsec_pkg;

    // reset phase: one cycle to catch the nonvolatile options, then run
    typedef enum logic [1:0] {
        FSEC_LOAD = 2'h1,
        FSEC_RUN = 2'h2
    } fsec_phase_t;

    // divider state
    typedef struct packed {
        logic [2:0] pre;
        logic [5:0] cnt;
        logic tick;
    } fsec_div_state_t;

    // key comparison state
    typedef struct packed {
        logic [7:0][7:0] keyb;
        logic [3:0] idx;
        logic bad;
    } fsec_key_state_t;

    // memory-side request from the cpu or the debug controller
    typedef struct packed {
        logic rd;
        logic wr;
        logic dbg;
        logic [15:0] addr;
        logic [7:0] wdata;
    } fsec_mem_req_t;

    // top-level state
    typedef struct packed {
        fsec_phase_t phase;
        logic [7:0] opt;
        logic div_loaded;
        logic prescale;
        logic [5:0] divisor;
        logic [2:0] cfg;
        logic [31:0] prdata;
        logic slverr;
        logic cmd_start;
        logic [15:0] cmd_addr;
        logic [7:0] cmd_data;
        logic [7:0] mem_rdata;
    } fsec_top_state_t;

    // true for the eight-byte key window
    function automatic logic fsec_in_key(input logic [15:0] addr);
        fsec_in_key = (addr[15:3] == 13'(`FSEC_KEY_BASE >> 3));
    endfunction

endpackage

// ---- design/fsec_clkdiv.sv ----
// program/erase timing tick divider
`include "fsec_defines.svh"

module fsec_clkdiv (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic en_i,
    input wire logic prescale_i,
    input wire logic [5:0] divisor_i,
    output logic tick_o
);
    fsec_pkg::fsec_div_state_t s_reg; // registered state
    fsec_pkg::fsec_div_state_t s_next; // next state
    logic pre_tick; // one input cycle to the main divider

    // divide by eight first when asked, then by divisor plus one
    always_comb
    begin
        s_next = s_reg;
        s_next.tick = 1'b0;
        pre_tick = !prescale_i || (s_reg.pre == `FSEC_PRESCALE_LAST);
        if (!en_i)
        begin
            // no divisor yet: hold still so the first period is whole
            s_next.pre = 3'h0;
            s_next.cnt = 6'h00;
        end
        else
        begin
            s_next.pre = prescale_i ? s_reg.pre + 3'h1 : 3'h0;
            if (pre_tick)
            begin
                if (s_reg.cnt >= divisor_i)
                begin
                    s_next.cnt = 6'h00;
                    s_next.tick = 1'b1;
                end
                else
                begin
                    s_next.cnt = s_reg.cnt + 6'h01;
                end
            end
        end
    end

    // state register
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign tick_o = s_reg.tick;

    property p_div_two;
        @(posedge clk_i) disable iff (!rst_n_i)
        (tick_o && en_i && !prescale_i && divisor_i == 6'h01) |=> !tick_o ##1 tick_o;
    endproperty
    a_div_two: assert property (p_div_two) else $error("tick spacing wrong");

endmodule // fsec_clkdiv

// ---- design/fsec_keycmp.sv ----
// backdoor key capture and comparison
`include "fsec_defines.svh"

module fsec_keycmp (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic clear_i,
    input wire logic byte_we_i,
    input wire logic [2:0] byte_idx_i,
    input wire logic [7:0] byte_data_i,
    input wire logic [7:0][7:0] stored_backdoor_key_i,
    output logic match_o
);
    fsec_pkg::fsec_key_state_t s_reg; // registered state
    fsec_pkg::fsec_key_state_t s_next; // next state

    // bytes must come in ascending order, each exactly once
    always_comb
    begin
        s_next = s_reg;
        if (clear_i)
        begin
            s_next = '0;
        end
        else if (byte_we_i)
        begin
            if (s_reg.idx >= `FSEC_KEY_BYTES || {1'b0, byte_idx_i} != s_reg.idx)
                s_next.bad = 1'b1;
            else
                s_next.keyb[byte_idx_i] = byte_data_i;
            if (s_reg.idx < `FSEC_KEY_BYTES)
                s_next.idx = s_reg.idx + 4'h1;
        end
    end

    // state register
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    // a missing byte leaves idx short, so no match
    assign match_o = !s_reg.bad && s_reg.idx == `FSEC_KEY_BYTES
        && s_reg.keyb == stored_backdoor_key_i;

    property p_order;
        @(posedge clk_i) disable iff (!rst_n_i)
        (byte_we_i && !clear_i && {1'b0, byte_idx_i} != s_reg.idx) |=> !match_o;
    endproperty
    a_order: assert property (p_order) else $error("out of order key matched");

endmodule // fsec_keycmp

// ---- design/fsec_top.sv ----
// flash security and configuration block with apb register access
//
// The implementer's own choices: the APB register port and the address map.
`include "fsec_defines.svh"

module fsec_top (
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    // apb slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // nonvolatile contents from the array
    input wire logic [7:0] NV_OPTIONS_I,
    input wire logic [63:0] STORED_BACKDOOR_KEY_I,
    // memory requests from cpu or debug controller
    input wire logic MEM_RD_I,
    input wire logic MEM_WR_I,
    input wire logic MEM_DBG_I,
    input wire logic [15:0] MEM_ADDR_I,
    input wire logic [7:0] MEM_WDATA_I,
    input wire logic [7:0] FLASH_RDATA_I,
    output logic [7:0] MEM_RDATA_O,
    output logic MEM_DENY_O,
    // command sequencer side
    input wire logic BLANK_OK_I,
    output logic CMD_START_O,
    output logic [15:0] CMD_ADDR_O,
    output logic [7:0] CMD_DATA_O,
    // status
    output logic FLASH_TICK_O,
    output logic DIV_LOADED_O,
    output logic SECURE_O,
    output logic REDIRECT_EN_O
);
    fsec_pkg::fsec_top_state_t s_reg; // registered state
    fsec_pkg::fsec_top_state_t s_next; // next state
    fsec_pkg::fsec_mem_req_t mem; // bundled memory request
    logic apb_setup; // first cycle of an apb transfer
    logic apb_wr; // write taking effect at this edge
    logic secure; // current security decision
    logic key_wen; // key capture mode
    logic in_key; // request falls in the key window
    logic key_byte_we; // accepted key byte
    logic key_clear; // key capture being switched on
    logic key_eval; // key capture being switched off
    logic key_match; // captured key equals stored key
    logic key_unlock; // backdoor unlock this cycle
    logic blank_unlock; // blank check unlock this cycle
    logic addr_hit; // apb address is mapped

    // bundle the memory request
    always_comb
    begin
        mem.rd = MEM_RD_I;
        mem.wr = MEM_WR_I;
        mem.dbg = MEM_DBG_I;
        mem.addr = MEM_ADDR_I;
        mem.wdata = MEM_WDATA_I;
    end

    assign apb_setup = PSEL_I && !PENABLE_I;
    assign apb_wr = PSEL_I && PENABLE_I && PWRITE_I && s_reg.phase == fsec_pkg::FSEC_RUN;
    assign key_wen = s_reg.cfg[`FSEC_CFG_KEYWEN_BIT - 5];
    assign in_key = fsec_pkg::fsec_in_key(mem.addr);

    // only code 10 is unsecured; before the load the reset value keeps it secure
    assign secure = s_reg.opt[1:0] != `FSEC_SEC_UNSECURED;

    // debug reads and writes are refused while secure
    assign MEM_DENY_O = secure && mem.dbg && (mem.rd || mem.wr);

    // key bytes only from firmware; debug writes never reach the comparator
    assign key_byte_we = mem.wr && in_key && key_wen && !mem.dbg;

    // key enable edges made by config writes
    assign key_clear = apb_wr && PADDR_I == `FSEC_OFF_CONFIG
        && PWDATA_I[`FSEC_CFG_KEYWEN_BIT] && !key_wen;
    assign key_eval = apb_wr && PADDR_I == `FSEC_OFF_CONFIG
        && !PWDATA_I[`FSEC_CFG_KEYWEN_BIT] && key_wen;

    // the match only counts when the backdoor is enabled
    assign key_unlock = key_eval && key_match
        && s_reg.opt[`FSEC_OPT_BACKDOOR_ENABLE_BIT];
    assign blank_unlock = BLANK_OK_I && s_reg.phase == fsec_pkg::FSEC_RUN;

    assign addr_hit = PADDR_I == `FSEC_OFF_DIVIDER || PADDR_I == `FSEC_OFF_OPTIONS
        || PADDR_I == `FSEC_OFF_CONFIG || PADDR_I == `FSEC_OFF_STATUS;

    // next-state logic for registers, reads and the memory side
    always_comb
    begin
        s_next = s_reg;
        s_next.cmd_start = 1'b0;
        case (s_reg.phase)
            fsec_pkg::FSEC_LOAD:
            begin
                // catch the nonvolatile byte after reset release
                s_next.opt = NV_OPTIONS_I & `FSEC_OPT_IMPL_MASK;
                s_next.phase = fsec_pkg::FSEC_RUN;
            end
            fsec_pkg::FSEC_RUN:
            begin
                // apb writes; the options word is not writable at all
                if (apb_wr)
                begin
                    if (PADDR_I == `FSEC_OFF_DIVIDER && !s_reg.div_loaded)
                    begin
                        // divider is write-once until the next reset
                        s_next.div_loaded = 1'b1;
                        s_next.prescale = PWDATA_I[`FSEC_DIV_PRESCALE_BIT];
                        s_next.divisor = PWDATA_I[5:0];
                    end
                    else if (PADDR_I == `FSEC_OFF_CONFIG)
                    begin
                        s_next.cfg = PWDATA_I[7:5];
                    end
                end
                // either unlock path forces the unsecured code
                if (key_unlock || blank_unlock)
                    s_next.opt[1:0] = `FSEC_SEC_UNSECURED;
                // key window writes start a command only outside capture mode
                if (mem.wr && !MEM_DENY_O && !(in_key && key_wen))
                begin
                    s_next.cmd_start = 1'b1;
                    s_next.cmd_addr = mem.addr;
                    s_next.cmd_data = mem.wdata;
                end
            end
            default:
            begin
                s_next.phase = fsec_pkg::FSEC_LOAD;
            end
        endcase
        // read data is prepared in the setup cycle, so the slave is zero-wait
        if (apb_setup)
        begin
            s_next.slverr = !addr_hit;
            s_next.prdata = 32'h0000_0000;
            if (PADDR_I == `FSEC_OFF_DIVIDER)
                s_next.prdata[7:0] = {s_reg.div_loaded, s_reg.prescale, s_reg.divisor};
            else if (PADDR_I == `FSEC_OFF_OPTIONS)
                s_next.prdata[7:0] = s_reg.opt & `FSEC_OPT_IMPL_MASK;
            else if (PADDR_I == `FSEC_OFF_CONFIG)
                s_next.prdata[7:0] = {s_reg.cfg, 5'h00};
            else if (PADDR_I == `FSEC_OFF_STATUS)
            begin
                s_next.prdata[`FSEC_STAT_SECURE_BIT] = secure;
                s_next.prdata[`FSEC_STAT_LOADED_BIT] = s_reg.phase == fsec_pkg::FSEC_RUN;
            end
        end
        // memory reads: capture mode or a refused debug read give invalid data
        if (mem.rd)
        begin
            if (key_wen || MEM_DENY_O)
                s_next.mem_rdata = `FSEC_INVALID_READ;
            else
                s_next.mem_rdata = FLASH_RDATA_I;
        end
    end

    // single state register; reset values are constants, the load follows release
    always_ff @(posedge CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            s_reg <= '0;
            s_reg.phase <= fsec_pkg::FSEC_LOAD;
            s_reg.opt <= `FSEC_OPT_RESET;
            s_reg.cfg <= `FSEC_CFG_RESET;
            {s_reg.prescale, s_reg.divisor} <= `FSEC_DIV_RESET;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // program/erase timing tick, held off until the divider is written
    fsec_clkdiv u_clkdiv (
        .clk_i(CLK_I),
        .rst_n_i(RESET_N_I),
        .en_i(s_reg.div_loaded),
        .prescale_i(s_reg.prescale),
        .divisor_i(s_reg.divisor),
        .tick_o(FLASH_TICK_O)
    );

    // key capture and comparison
    fsec_keycmp u_keycmp (
        .clk_i(CLK_I),
        .rst_n_i(RESET_N_I),
        .clear_i(key_clear),
        .byte_we_i(key_byte_we),
        .byte_idx_i(mem.addr[2:0]),
        .byte_data_i(mem.wdata),
        .stored_backdoor_key_i(STORED_BACKDOOR_KEY_I),
        .match_o(key_match)
    );

    // outputs
    assign PRDATA_O = s_reg.prdata;
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = PSEL_I && PENABLE_I && s_reg.slverr;
    assign MEM_RDATA_O = s_reg.mem_rdata;
    assign CMD_START_O = s_reg.cmd_start;
    assign CMD_ADDR_O = s_reg.cmd_addr;
    assign CMD_DATA_O = s_reg.cmd_data;
    assign DIV_LOADED_O = s_reg.div_loaded;
    assign SECURE_O = secure;
    assign REDIRECT_EN_O = !s_reg.opt[`FSEC_OPT_REDIR_BIT];

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);

    property p_load;
        s_reg.phase == fsec_pkg::FSEC_LOAD
            |=> s_reg.opt == ($past(NV_OPTIONS_I) & `FSEC_OPT_IMPL_MASK);
    endproperty
    a_load: assert property (p_load) else $error("options not loaded");

    property p_opt_zero;
        s_reg.opt[5:2] == 4'h0;
    endproperty
    a_opt_zero: assert property (p_opt_zero) else $error("options reserved bits set");

    property p_opt_ro;
        (apb_wr && PADDR_I == `FSEC_OFF_OPTIONS && !key_unlock && !blank_unlock)
            |=> s_reg.opt == $past(s_reg.opt);
    endproperty
    a_opt_ro: assert property (p_opt_ro) else $error("options changed by write");

    property p_no_key;
        // the load cycle may legally change the code, so only the run phase is watched
        s_reg.phase == fsec_pkg::FSEC_RUN && !s_reg.opt[`FSEC_OPT_BACKDOOR_ENABLE_BIT] && !blank_unlock
            |=> $stable(SECURE_O);
    endproperty
    a_no_key: assert property (p_no_key) else $error("unlock with backdoor off");

    property p_dbg_key;
        (mem.dbg && mem.wr && in_key) |-> !key_byte_we;
    endproperty
    a_dbg_key: assert property (p_dbg_key) else $error("debug key write taken");

    property p_unlock;
        (key_unlock || blank_unlock) |=> !SECURE_O ##1 !SECURE_O;
    endproperty
    a_unlock: assert property (p_unlock) else $error("unlock did not stick");

    property p_redir;
        REDIRECT_EN_O != s_reg.opt[6];
    endproperty
    a_redir: assert property (p_redir) else $error("redirect enable wrong");

    property p_deny;
        (SECURE_O && MEM_DBG_I && MEM_RD_I) |-> MEM_DENY_O ##1 MEM_RDATA_O == `FSEC_INVALID_READ;
    endproperty
    a_deny: assert property (p_deny) else $error("secure debug read passed");

    property p_launch;
        (s_reg.phase == fsec_pkg::FSEC_RUN && mem.wr && in_key && !key_wen && !MEM_DENY_O)
            |=> CMD_START_O && CMD_ADDR_O == $past(MEM_ADDR_I);
    endproperty
    a_launch: assert property (p_launch) else $error("key window write no command");

    property p_capture;
        (mem.wr && in_key && key_wen) |=> !CMD_START_O;
    endproperty
    a_capture: assert property (p_capture) else $error("captured byte launched");

    property p_invalid;
        (MEM_RD_I && key_wen) |=> MEM_RDATA_O == `FSEC_INVALID_READ;
    endproperty
    a_invalid: assert property (p_invalid) else $error("read valid in key mode");

    property p_cfg_low;
        (apb_setup && PADDR_I == `FSEC_OFF_CONFIG) |=> PRDATA_O[4:0] == 5'h00
            && PRDATA_O[7:5] == s_reg.cfg;
    endproperty
    a_cfg_low: assert property (p_cfg_low) else $error("config read wrong");

endmodule // fsec_top

// ---- bench/fsec_cpu_model.sv ----
// cpu and debug memory master with a small flash array model
module fsec_cpu_model (
    input wire logic clk_i,
    input wire logic [7:0] mem_rdata_i,
    input wire logic mem_deny_i,
    input wire logic cmd_start_i,
    output logic mem_rd_o,
    output logic mem_wr_o,
    output logic mem_dbg_o,
    output logic [15:0] mem_addr_o,
    output logic [7:0] mem_wdata_o,
    output logic [7:0] flash_rdata_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // array data follows the address; off a read it is inverted so stale data shows
    assign flash_rdata_o = mem_rd_o ? (mem_addr_o[7:0] ^ 8'h5A) : ~(mem_addr_o[7:0] ^ 8'h5A);

    // idle master at time zero
    initial
    begin
        mem_rd_o = 1'b0;
        mem_wr_o = 1'b0;
        mem_dbg_o = 1'b0;
        mem_addr_o = 16'h0000;
        mem_wdata_o = 8'h00;
    end

    // one request with a single-cycle strobe; deny is seen in the request cycle,
    // data and command start are sampled just after the taking edge
    task automatic access(input logic rd, input logic wr, input logic dbg,
                          input logic [15:0] addr, input logic [7:0] wdata,
                          output logic deny, output logic [7:0] rdata, output logic started);
        @(posedge clk_i);
        mem_rd_o <= rd;
        mem_wr_o <= wr;
        mem_dbg_o <= dbg;
        mem_addr_o <= addr;
        mem_wdata_o <= wdata;
        #1;
        deny = mem_deny_i;
        @(posedge clk_i);
        mem_rd_o <= 1'b0;
        mem_wr_o <= 1'b0;
        mem_dbg_o <= 1'b0;
        // released lines must not keep the last value
        mem_addr_o <= ~addr;
        mem_wdata_o <= ~wdata;
        #1;
        rdata = mem_rdata_i;
        started = cmd_start_i;
    endtask
endmodule // fsec_cpu_model

// ---- bench/flash_security_options_test.sv ----
// self-checking bench of the flash security block
`include "fsec_defines.svh"

module flash_security_options_test;
    timeunit 1ns;
    timeprecision 100ps;

    // stored key of the array, value is arbitrary
    localparam logic [63:0] KEY = 64'h0123_4567_89AB_CDEF;

    logic clk, reset_n, psel, penable, pwrite, pready, pslverr, blank_ok;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, exp;
    logic [7:0] nv_opt, flash_rdata, mem_rdata, mrd, cmd_data, mem_wdata;
    logic [15:0] mem_addr, cmd_addr;
    logic mem_rd, mem_wr, mem_dbg, mem_deny, cmd_start, tick, div_loaded, secure, redirect_en;
    logic err, deny, started;
    int num_errors, comparisons, period;
    // options table: codes 11, 11, 10, 01, 00; the last sets the unused bits
    logic [7:0] nv_tab [5] = '{8'hFF, 8'h43, 8'h02, 8'h81, 8'h3C};
    // divider table: plain divide by 2, then prescaled divide by 512; at 8 ns even the
    // longest setting gives 4.1 us, short of the 5 us floor software must
    logic [6:0] div_tab [2] = '{7'h01, 7'h7F};

    fsec_top i_fsec_top (.CLK_I(clk), .RESET_N_I(reset_n), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .NV_OPTIONS_I(nv_opt),
        .STORED_BACKDOOR_KEY_I(KEY), .MEM_RD_I(mem_rd), .MEM_WR_I(mem_wr), .MEM_DBG_I(mem_dbg),
        .MEM_ADDR_I(mem_addr), .MEM_WDATA_I(mem_wdata), .FLASH_RDATA_I(flash_rdata),
        .MEM_RDATA_O(mem_rdata), .MEM_DENY_O(mem_deny), .BLANK_OK_I(blank_ok),
        .CMD_START_O(cmd_start), .CMD_ADDR_O(cmd_addr), .CMD_DATA_O(cmd_data),
        .FLASH_TICK_O(tick), .DIV_LOADED_O(div_loaded), .SECURE_O(secure),
        .REDIRECT_EN_O(redirect_en));

    fsec_cpu_model i_fsec_cpu_model (.clk_i(clk), .mem_rdata_i(mem_rdata), .mem_deny_i(mem_deny),
        .cmd_start_i(cmd_start), .mem_rd_o(mem_rd), .mem_wr_o(mem_wr), .mem_dbg_o(mem_dbg),
        .mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata), .flash_rdata_o(flash_rdata));

    // 125 MHz bus clock
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // compare and count; four-state equality so unknowns never match
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, want, seen);
        end
    endtask

    // counts and verdict, the single end of the run
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // apb transfer: setup, then access held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                       output logic [31:0] rdata, output logic slverr);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        // ready, read data and error are taken at the edge that ends the access
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1)
        begin
            num_errors++;
            finish_test();
        end
        rdata = prdata;
        slverr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~addr;
        pwdata <= ~wdata;
    endtask

    // reset for four cycles with a given nonvolatile options byte
    task automatic apply_reset(input logic [7:0] nv);
        @(posedge clk);
        reset_n <= 1'b0;
        nv_opt <= nv;
        repeat (3) @(posedge clk);
        #1;
        check("secure in reset", secure, 1'b1);
        @(posedge clk);
        reset_n <= 1'b1;
        // first edge after release is the options load
        repeat (2) @(posedge clk);
    endtask

    // cycles between two flash ticks, bounded so a dead divider cannot hang
    task automatic tick_period(output int cycles);
        int n;
        n = 0;
        cycles = 0;
        #1;
        while (tick !== 1'b1 && n < 2000)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        do
        begin
            @(posedge clk);
            #1;
            cycles++;
        end
        while (tick !== 1'b1 && cycles < 2000);
        if (n >= 2000 || cycles >= 2000)
        begin
            num_errors++;
            finish_test();
        end
    endtask

    // backdoor entry: capture on, eight key writes (pair order swapped on request), capture off
    task automatic key_entry(input logic [63:0] k, input logic swap, input logic dbg,
                             input logic exp_secure);
        int j;
        apb(1'b1, `FSEC_OFF_CONFIG, 32'h0000_0020, rd, err);
        i_fsec_cpu_model.access(1'b1, 1'b0, 1'b0, 16'h1234, 8'h00, deny, mrd, started);
        check("read while capturing", mrd, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            j = swap ? (i ^ 1) : i;
            i_fsec_cpu_model.access(1'b0, 1'b1, dbg, 16'hFFB0 + j[15:0], k[8 * j +: 8], deny, mrd,
                                    started);
            check("key write command", started, 1'b0);
        end
        apb(1'b1, `FSEC_OFF_CONFIG, 32'h0000_0000, rd, err);
        @(posedge clk);
        #1;
        check("secure after key", secure, exp_secure);
    endtask

    // main sequence
    initial
    begin
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        nv_opt = 8'hFF;
        blank_ok = 1'b0;
        num_errors = 0;
        comparisons = 0;
        // options copy, read-only shadow, redirect and security decode
        foreach (nv_tab[i])
        begin
            apply_reset(nv_tab[i]);
            exp = {24'h000000, nv_tab[i][7:6], 4'h0, nv_tab[i][1:0]};
            apb(1'b0, `FSEC_OFF_OPTIONS, 32'h0000_0000, rd, err);
            check("options", rd, exp);
            check("options error", err, 1'b0);
            apb(1'b1, `FSEC_OFF_OPTIONS, ~exp, rd, err);
            apb(1'b0, `FSEC_OFF_OPTIONS, 32'h0000_0000, rd, err);
            check("options after write", rd, exp);
            check("redirect", redirect_en, !nv_tab[i][6]);
            apb(1'b0, `FSEC_OFF_STATUS, 32'h0000_0000, rd, err);
            check("status secure", rd[0], nv_tab[i][1:0] != 2'h2);
            check("status loaded", rd[1], 1'b1);
        end
        $display("test options done");
        // configuration bits and an unmapped place
        apb(1'b1, `FSEC_OFF_CONFIG, 32'h0000_00FF, rd, err);
        apb(1'b0, `FSEC_OFF_CONFIG, 32'h0000_0000, rd, err);
        check("config", rd, 32'h0000_00E0);
        apb(1'b1, `FSEC_OFF_CONFIG, 32'h0000_0000, rd, err);
        apb(1'b0, `FSEC_OFF_CONFIG, 32'h0000_0000, rd, err);
        check("config cleared", rd, 32'h0000_0000);
        apb(1'b0, 12'h010, 32'h0000_0000, rd, err);
        check("unmapped error", err, 1'b1);
        check("unmapped data", rd, 32'h0000_0000);
        $display("test config done");
        // divider: write once, then tick period from prescale and divisor
        foreach (div_tab[i])
        begin
            apply_reset(8'hFF);
            apb(1'b1, `FSEC_OFF_DIVIDER, {25'h0, div_tab[i]}, rd, err);
            apb(1'b1, `FSEC_OFF_DIVIDER, 32'h0000_0005, rd, err);
            apb(1'b0, `FSEC_OFF_DIVIDER, 32'h0000_0000, rd, err);
            check("divider", rd, {24'h000000, 1'b1, div_tab[i]});
            check("divider loaded", div_loaded, 1'b1);
            tick_period(period);
            check("tick period", period, (div_tab[i][6] ? 32'h8 : 32'h1) *
                  ({26'h0, div_tab[i][5:0]} + 32'h1));
        end
        $display("test divider done");
        // secure part, backdoor on: command launch, debug block, key attempts
        i_fsec_cpu_model.access(1'b0, 1'b1, 1'b0, 16'hFFB3, 8'hA5, deny, mrd, started);
        check("key window command", started, 1'b1);
        check("command address", cmd_addr, 16'hFFB3);
        check("command data", cmd_data, 8'hA5);
        i_fsec_cpu_model.access(1'b1, 1'b0, 1'b1, 16'h1234, 8'h00, deny, mrd, started);
        check("debug denied", deny, 1'b1);
        check("debug read blocked", mrd, 8'h00);
        key_entry(KEY ^ 64'h1, 1'b0, 1'b0, 1'b1);
        key_entry(KEY, 1'b1, 1'b0, 1'b1);
        key_entry(KEY, 1'b0, 1'b1, 1'b1);
        key_entry(KEY, 1'b0, 1'b0, 1'b0);
        apb(1'b0, `FSEC_OFF_OPTIONS, 32'h0000_0000, rd, err);
        check("code after key", rd, 32'h0000_00C2);
        i_fsec_cpu_model.access(1'b1, 1'b0, 1'b1, 16'h1234, 8'h00, deny, mrd, started);
        check("debug allowed", deny, 1'b0);
        check("debug read data", mrd, 8'h6E);
        $display("test backdoor done");
        // backdoor off: a right key stays locked, a blank check unlocks
        apply_reset(8'h43);
        key_entry(KEY, 1'b0, 1'b0, 1'b1);
        @(posedge clk);
        blank_ok <= 1'b1;
        @(posedge clk);
        blank_ok <= 1'b0;
        @(posedge clk);
        #1;
        check("secure after blank", secure, 1'b0);
        $display("test blank done");
        finish_test();
    end
endmodule // flash_security_options_test
